// >>> shared/asram_consts.svh
// Constants for the async SRAM host controller
`ifndef ASRAM_CONSTS_SVH
`define ASRAM_CONSTS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define ASRAM_ADDR_W      15
`define ASRAM_DATA_W      8

// ----------------------------------------
// Timing, in ns as printed, and derived cycles at the clock rate
// ----------------------------------------
`define ASRAM_CLK_NS      40
`define ASRAM_TRC_NS      70
`define ASRAM_TAA_NS      70
`define ASRAM_TPWE_NS     50
`define ASRAM_TSD_NS      30
`define ASRAM_THZWE_NS    25
`define ASRAM_THZOE_NS    25
`define ASRAM_CEIL(n)     (((n) + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_RD_CYC      `ASRAM_CEIL(`ASRAM_TAA_NS)
`define ASRAM_WR_CYC      `ASRAM_CEIL(`ASRAM_TPWE_NS + `ASRAM_THZWE_NS + `ASRAM_TSD_NS)
`define ASRAM_TURN_CYC    `ASRAM_CEIL(`ASRAM_THZOE_NS)

`endif

// >>> shared/asram_pkg.sv
// Types for the async SRAM host controller
package asram_pkg;

	typedef enum logic [2:0] {
		ASRAM_IDLE,
		ASRAM_RD,
		ASRAM_WR,
		ASRAM_WR_END,
		ASRAM_TURN
	} asram_state_t;

endpackage : asram_pkg

// >>> logic/asram_wait.sv
// Down counter that times each phase of a memory cycle
`timescale 1ns/1ps
`include "asram_consts.svh"

module asram_wait #(
	parameter int CW = 4
) (
	input  wire logic          clk,   // System clock
	input  wire logic          nrst,  // Async reset, active low
	input  wire logic          load,  // Load a new count
	input  wire logic [CW-1:0] count, // Cycles to wait
	output logic               done   // Count has run out
);

	typedef struct packed {
		logic [CW-1:0] cnt;
	} asram_wait_t;

	asram_wait_t st_ff;
	asram_wait_t nxt_st;

	if (CW < 2) begin : g_bad_cw
		$error("asram_wait: CW too small");
	end

	always_comb begin
		nxt_st = st_ff;
		if (load) begin
			nxt_st.cnt = count;
		end else if (st_ff.cnt != '0) begin
			nxt_st.cnt = st_ff.cnt - {{(CW-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Plain compare: the sequencer reloads on done, so done must not look at load
	assign done = (st_ff.cnt == '0);

endmodule : asram_wait

// >>> logic/asram_host.sv
// Host controller that runs read and write cycles on a 32K x 8 async SRAM port
// Contract
// - A write runs only over the overlap of select low and write strobe low and ends when either rises.
// - The host holds write data around the rising edge that ends the write.
// - The host must not drive the data lines while the memory still drives them.
// - A strobe-controlled write with output drive low lasts at least float delay plus data set-up.
// - For a read the host presents the address no later than the select falling edge.
`timescale 1ns/1ps
`include "asram_consts.svh"

module asram_host #(
	parameter int AW      = `ASRAM_ADDR_W,
	parameter int DW      = `ASRAM_DATA_W,
	parameter int RD_CYC  = `ASRAM_RD_CYC,
	parameter int WR_CYC  = `ASRAM_WR_CYC,
	parameter int TURN_CYC = `ASRAM_TURN_CYC
) (
	input  wire logic          clk,        // System clock, 25 MHz
	input  wire logic          nrst,       // Async reset, active low
	input  wire logic          req_valid,  // Request present
	input  wire logic          req_write,  // 1 write, 0 read
	input  wire logic [AW-1:0] req_addr,   // Word address
	input  wire logic [DW-1:0] req_wdata,  // Write byte
	output logic               req_ready,  // Request taken this cycle when valid
	output logic               rsp_valid,  // Read data pulse
	output logic [DW-1:0]      rsp_rdata,  // Read byte
	output logic               wr_done,    // Write finished pulse
	output logic [AW-1:0]      mem_addr,   // Memory word address
	output logic               mem_sel_n,  // Chip select, active low
	output logic               mem_wr_n,   // Write strobe, active low
	output logic               mem_oe_n,   // Output drive, active low
	output logic [DW-1:0]      mem_dq_o,   // Data lines, host side
	output logic               mem_dq_oe_n, // Data drive enable, low drives
	input  wire logic [DW-1:0] mem_dq_i    // Data lines as seen at the pins
);

	// ----------------------------------------
	// Types and state
	// ----------------------------------------
	// Four timer bits cover every phase up to fifteen cycles
	localparam int CW = 4;

	typedef struct packed {
		asram_pkg::asram_state_t state;
		logic                    ready;
		logic                    rvalid;
		logic [DW-1:0]           rdata;
		logic                    wdone;
		logic [AW-1:0]           addr;
		logic                    sel_n;
		logic                    wr_n;
		logic                    oe_n;
		logic [DW-1:0]           dq;
		logic                    dq_oe_n;
		logic [DW-1:0]           sync1;
		logic [DW-1:0]           sync2;
	} asram_host_t;

	asram_host_t st_ff;
	asram_host_t nxt_st;
	logic        wt_load;
	logic [CW-1:0] wt_count;
	logic        wt_done;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	// The read wait adds two synchroniser cycles on top of RD_CYC,
	// so every count must stay at or below the top of the timer
	if (AW != `ASRAM_ADDR_W || DW != `ASRAM_DATA_W) begin : g_bad_width
		$error("asram_host: port widths must match the memory");
	end
	if (RD_CYC < 1 || WR_CYC < 1 || TURN_CYC < 1 || RD_CYC > 13 || WR_CYC > 13 || TURN_CYC > 13) begin : g_bad_cyc
		$error("asram_host: cycle counts out of range");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Every phase length is cut to the timer width in one place
	function automatic logic [CW-1:0] to_cnt(input int n);
		return CW'(n);
	endfunction : to_cnt

	// ----------------------------------------
	// Phase timer
	// ----------------------------------------
	// Reloaded in the same cycle it runs out only when a read hands over to the turn gap; a write reloads it a cycle later, in ASRAM_WR_END
	asram_wait #(
		.CW(CW)
	) u_wait (
		.clk  (clk),
		.nrst (nrst),
		.load (wt_load),
		.count(wt_count),
		.done (wt_done)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		nxt_st       = st_ff;
		wt_load      = 1'b0;
		wt_count     = '0;
		nxt_st.rvalid = 1'b0;
		nxt_st.wdone  = 1'b0;
		nxt_st.ready  = 1'b0;
		// Pin data passes two flops before use
		nxt_st.sync1 = mem_dq_i;
		nxt_st.sync2 = st_ff.sync1;
		case (st_ff.state)
			asram_pkg::ASRAM_IDLE: begin
				// Pins rest released between cycles, keeping the memory in standby
				nxt_st.sel_n   = 1'b1;
				nxt_st.wr_n    = 1'b1;
				nxt_st.oe_n    = 1'b1;
				nxt_st.dq_oe_n = 1'b1;
				if (req_valid && st_ff.ready) begin
					// Address goes out with the select edge, never after it
					nxt_st.addr  = req_addr;
					nxt_st.sel_n = 1'b0;
					wt_load      = 1'b1;
					if (req_write) begin
						// Output drive stays high so the memory never contends with us
						nxt_st.dq      = req_wdata;
						nxt_st.dq_oe_n = 1'b0;
						nxt_st.wr_n    = 1'b0;
						// Strobe stays low WR_CYC plus one cycles, past float delay and set-up
						wt_count       = to_cnt(WR_CYC);
						nxt_st.state   = asram_pkg::ASRAM_WR;
					end else begin
						nxt_st.oe_n  = 1'b0;
						// Two extra cycles cover the input synchroniser
						wt_count     = to_cnt(RD_CYC + 2);
						nxt_st.state = asram_pkg::ASRAM_RD;
					end
				end else begin
					nxt_st.ready = 1'b1;
				end
			end
			asram_pkg::ASRAM_RD: begin
				if (wt_done) begin
					nxt_st.rdata  = st_ff.sync2;
					nxt_st.rvalid = 1'b1;
					// Memory floats within the turn gap before anyone drives again
					nxt_st.sel_n  = 1'b1;
					nxt_st.oe_n   = 1'b1;
					wt_load       = 1'b1;
					wt_count      = to_cnt(TURN_CYC);
					nxt_st.state  = asram_pkg::ASRAM_TURN;
				end
			end
			asram_pkg::ASRAM_WR: begin
				if (wt_done) begin
					// Strobe ends the write; data and address held one more cycle
					nxt_st.wr_n  = 1'b1;
					nxt_st.state = asram_pkg::ASRAM_WR_END;
				end
			end
			asram_pkg::ASRAM_WR_END: begin
				// Select rises a cycle after the strobe, so the two never rise together
				nxt_st.sel_n   = 1'b1;
				nxt_st.dq_oe_n = 1'b1;
				nxt_st.wdone   = 1'b1;
				wt_load        = 1'b1;
				wt_count       = to_cnt(1);
				nxt_st.state   = asram_pkg::ASRAM_TURN;
			end
			asram_pkg::ASRAM_TURN: begin
				// Gap lets the memory float before the next cycle drives the bus
				if (wt_done) begin
					nxt_st.ready = 1'b1;
					nxt_st.state = asram_pkg::ASRAM_IDLE;
				end
			end
			default: begin
				nxt_st.state = asram_pkg::ASRAM_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Pins come out of reset released, so the memory sits deselected
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff         <= '0;
			st_ff.state   <= asram_pkg::ASRAM_IDLE;
			st_ff.sel_n   <= 1'b1;
			st_ff.wr_n    <= 1'b1;
			st_ff.oe_n    <= 1'b1;
			st_ff.dq_oe_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every pin comes straight from a flop, so no glitch reaches the memory
	assign req_ready   = st_ff.ready;
	assign rsp_valid   = st_ff.rvalid;
	assign rsp_rdata   = st_ff.rdata;
	assign wr_done     = st_ff.wdone;
	assign mem_addr    = st_ff.addr;
	assign mem_sel_n   = st_ff.sel_n;
	assign mem_wr_n    = st_ff.wr_n;
	assign mem_oe_n    = st_ff.oe_n;
	assign mem_dq_o    = st_ff.dq;
	assign mem_dq_oe_n = st_ff.dq_oe_n;

endmodule : asram_host

// >>> tb/asram_host_chk.sv
// Port protocol checker for the async SRAM host
`timescale 1ns/1ps
module asram_host_chk #(
	parameter int AW = 15,
	parameter int DW = 8
) (
	input wire logic clk, // clock
	input wire logic nrst, // reset
	input wire logic req_valid, // request
	input wire logic req_ready, // ready
	input wire logic [AW-1:0] req_addr, // address in
	input wire logic wr_done, // write end
	input wire logic [AW-1:0] mem_addr, // address out
	input wire logic mem_sel_n, // select
	input wire logic mem_wr_n, // strobe
	input wire logic mem_oe_n, // drive
	input wire logic [DW-1:0] mem_dq_o, // data
	input wire logic mem_dq_oe_n // data enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	take_addr_a: assert property (req_valid && req_ready |=> !mem_sel_n && mem_addr == $past(req_addr))
		else $error("select late");
	no_fight_a: assert property (!mem_dq_oe_n |-> mem_oe_n)
		else $error("drive clash");
	wr_hold_a: assert property ($rose(mem_wr_n) |-> !mem_sel_n && !mem_dq_oe_n && $stable(mem_dq_o))
		else $error("data hold");
	wr_len_a: assert property ($fell(mem_wr_n) |-> (!mem_wr_n && !mem_sel_n) [*2])
		else $error("strobe short");
	sel_gap_a: assert property ($rose(mem_sel_n) |=> mem_sel_n)
		else $error("no gap");
	wr_end_a: assert property (wr_done |-> $rose(mem_sel_n) && mem_wr_n && mem_dq_oe_n)
		else $error("write end");
	rd_open_a: assert property (!mem_oe_n |-> !mem_sel_n && mem_wr_n && mem_dq_oe_n)
		else $error("read window");
	rise_apart_a: assert property ($rose(mem_sel_n) |-> !$rose(mem_wr_n))
		else $error("joint rise");
endmodule : asram_host_chk

bind asram_host asram_host_chk #(
	.AW(AW),
	.DW(DW)
) u_chk (
	.clk        (clk),
	.nrst       (nrst),
	.req_valid  (req_valid),
	.req_ready  (req_ready),
	.req_addr   (req_addr),
	.wr_done    (wr_done),
	.mem_addr   (mem_addr),
	.mem_sel_n  (mem_sel_n),
	.mem_wr_n   (mem_wr_n),
	.mem_oe_n   (mem_oe_n),
	.mem_dq_o   (mem_dq_o),
	.mem_dq_oe_n(mem_dq_oe_n)
);

// >>> tb/asram_mem_model.sv
// Behavioural 32K x 8 async SRAM facing the host
`timescale 1ns/1ps
module asram_mem_model #(
	parameter int DLY = 70 // access time, ns
) (
	input wire logic [14:0] mem_addr, // address
	input wire logic mem_sel_n, // select
	input wire logic mem_wr_n, // strobe
	input wire logic mem_oe_n, // drive
	input wire logic [7:0] mem_dq_o, // host data
	input wire logic mem_dq_oe_n, // host enable
	output logic [7:0] mem_dq_i // wire level
);
	logic [7:0] mem [0:32767];
	logic [7:0] last_v = 8'h5a;
	logic wr_act, rd_act, rd_on;

	assign wr_act = !mem_sel_n && !mem_wr_n;
	assign rd_act = !mem_sel_n && !mem_oe_n && mem_wr_n;
	// Slow both to drive and to float
	assign #(DLY) rd_on = rd_act;

	// Byte lands when the overlap ends; nothing else writes
	always @(negedge wr_act) mem[mem_addr] = mem_dq_i;

	// Released lines show the inverse of the last level
	always @* begin
		if (!mem_dq_oe_n) mem_dq_i = mem_dq_o;
		else if (rd_on) mem_dq_i = mem[mem_addr];
		else mem_dq_i = ~last_v;
	end
	always @(mem_dq_i) if (!mem_dq_oe_n || rd_on) last_v = mem_dq_i;
endmodule : asram_mem_model

// >>> tb/asram_host_test.sv
// Self-checking bench for the async SRAM host
`timescale 1ns/1ps
module asram_host_test;
	logic clk, nrst, req_valid, req_write, req_ready, rsp_valid, wr_done;
	logic mem_sel_n, mem_wr_n, mem_oe_n, mem_dq_oe_n;
	logic [14:0] req_addr, mem_addr;
	logic [7:0] req_wdata, rsp_rdata, mem_dq_o, mem_dq_i;
	logic [8:0] exp_q[$];
	logic [7:0] mdl[int];
	int error_cnt, num_checks, wa[$], k;

	asram_host u_asram_host (
		.clk        (clk),
		.nrst       (nrst),
		.req_valid  (req_valid),
		.req_write  (req_write),
		.req_addr   (req_addr),
		.req_wdata  (req_wdata),
		.req_ready  (req_ready),
		.rsp_valid  (rsp_valid),
		.rsp_rdata  (rsp_rdata),
		.wr_done    (wr_done),
		.mem_addr   (mem_addr),
		.mem_sel_n  (mem_sel_n),
		.mem_wr_n   (mem_wr_n),
		.mem_oe_n   (mem_oe_n),
		.mem_dq_o   (mem_dq_o),
		.mem_dq_oe_n(mem_dq_oe_n),
		.mem_dq_i   (mem_dq_i)
	);
	asram_mem_model u_asram_mem_model (
		.mem_addr   (mem_addr),
		.mem_sel_n  (mem_sel_n),
		.mem_wr_n   (mem_wr_n),
		.mem_oe_n   (mem_oe_n),
		.mem_dq_o   (mem_dq_o),
		.mem_dq_oe_n(mem_dq_oe_n),
		.mem_dq_i   (mem_dq_i)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic fail(input string m);
		error_cnt++;
		$display("wrong value at %0t: %s", $time, m);
	endtask : fail

	task automatic chk_rd(input logic [8:0] e);
		num_checks++;
		if ({1'b1, rsp_rdata} !== e) fail("read byte");
	endtask : chk_rd

	task automatic chk_wr(input logic [8:0] e);
		num_checks++;
		if (e !== 9'h000) fail("write done");
	endtask : chk_wr

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// Pulses stand one cycle, so look mid-cycle
	always @(negedge clk) begin
		if (rsp_valid === 1'b1 || wr_done === 1'b1) begin
			if (exp_q.size() == 0) fail("extra answer");
			else if (rsp_valid === 1'b1) chk_rd(exp_q.pop_front());
			else chk_wr(exp_q.pop_front());
		end
	end

	// Held until taken, so early requests are refused, not lost
	task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
		int n;
		@(negedge clk);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		for (n = 0; req_ready !== 1'b1 && n < 40; n++) @(negedge clk);
		if (n == 40) fail("not taken");
		if (w) mdl[a] = d;
		exp_q.push_back(w ? 9'h000 : {1'b1, mdl[a]});
		@(negedge clk);
		req_valid = 1'b0;
	endtask : req

	initial begin
		k = $urandom(1454);
		{nrst, req_valid, req_write, req_addr, req_wdata} = '0;
		repeat (10) @(negedge clk);
		num_checks++;
		if ({mem_sel_n, mem_wr_n, mem_oe_n, mem_dq_oe_n} !== 4'hf) fail("reset levels");
		nrst = 1'b1;
		wa = '{0, 32767};
		repeat (20) wa.push_back($urandom_range(32767));
		foreach (wa[i]) req(1'b1, wa[i][14:0], 8'($urandom));
		for (int i = 21; i >= 0; i--) req(1'b0, wa[i][14:0], 8'h00);
		req(1'b1, 15'h0000, ~mdl[0]);
		req(1'b0, 15'h0000, 8'h00);
		req(1'b0, 15'h7fff, 8'h00);
		repeat (40) begin
			k = wa[$urandom_range(21)];
			req(1'($urandom), k[14:0], 8'($urandom));
		end
		for (k = 0; k < 50 && exp_q.size() > 0; k++) @(negedge clk);
		// Reset in mid-run must release the pins and leave the stored bytes alone
		nrst = 1'b0;
		@(negedge clk);
		num_checks++;
		if ({mem_sel_n, mem_wr_n, mem_oe_n, mem_dq_oe_n, req_ready} !== 5'h1e) fail("mid reset");
		nrst = 1'b1;
		req(1'b0, 15'h0000, 8'h00);
		req(1'b0, 15'h7fff, 8'h00);
		for (k = 0; k < 50 && exp_q.size() > 0; k++) @(negedge clk);
		num_checks++;
		if (exp_q.size() != 0) fail("answers missing");
		final_report();
	end

	initial begin
		#200us;
		fail("timeout");
		final_report();
	end
endmodule : asram_host_test
